// [rtl/smp_pkg.sv]
// Package: constants, register map, modes and carriers of the stop mode power controller
package smp_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int SMP_CLK_PERIOD_NS = 10;
    localparam int SMP_WAKE_TICK_NS = 1000000;
    localparam int SMP_WAKE_TICK_CYCLES = SMP_WAKE_TICK_NS / SMP_CLK_PERIOD_NS;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [2:0] SMP_A_PWR_ONE = 3'h0;
    localparam logic [2:0] SMP_A_PWR_TWO = 3'h1;
    localparam logic [2:0] SMP_A_DEBUG = 3'h2;
    localparam logic [2:0] SMP_A_SYS_OPT = 3'h3;
    localparam logic [2:0] SMP_A_PERIODIC = 3'h4;
    localparam logic [2:0] SMP_A_CLKGEN = 3'h5;
    localparam logic [2:0] SMP_A_KBD_EN = 3'h6;
    localparam logic [2:0] SMP_A_STATUS = 3'h7;

    // Field positions
    localparam int SMP_B_SVM_EN = 0;
    localparam int SMP_B_SVM_STOP_EN = 1;
    localparam int SMP_B_PPDC = 0;
    localparam int SMP_B_PDC = 1;
    localparam int SMP_B_PIN_ACK = 2;
    localparam int SMP_B_PPD_FLAG = 3;
    localparam int SMP_B_DBG_EN = 0;
    localparam int SMP_B_STOP_EN = 0;
    localparam int SMP_B_IRQ_EN = 1;
    localparam int SMP_B_RATE_LO = 0;
    localparam int SMP_B_PER_FLAG = 3;
    localparam int SMP_B_OSC_KEEP = 0;
    localparam int SMP_B_REF_KEEP = 1;
    localparam int SMP_B_ST_LO = 0;
    localparam int SMP_B_SRC_LO = 3;

    localparam logic [2:0] SMP_RATE_OFF = 3'h0;
    localparam logic [15:0] SMP_RATE_BASE = 16'h0008;

    // ----------------------------------------
    // Modes
    // ----------------------------------------
    typedef enum logic [2:0] {
        SMP_RUN,
        SMP_LIGHT,
        SMP_MID,
        SMP_DEEP
    } smp_state_e;

    typedef enum logic [2:0] {
        SMP_SRC_NONE,
        SMP_SRC_RESET,
        SMP_SRC_IRQ,
        SMP_SRC_KBD,
        SMP_SRC_PERIODIC,
        SMP_SRC_DEBUG
    } smp_src_e;

    typedef enum logic [1:0] {
        SMP_CG_ACTIVE,
        SMP_CG_STANDBY,
        SMP_CG_OFF
    } smp_cg_e;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic periph_clk_en;
        logic debug_clk_en;
        smp_cg_e clkgen_mode;
        logic osc_keep;
        logic ref_keep;
        logic regulator_standby;
        logic converter_standby;
        logic pin_latch;
        logic pin_force_reset;
        logic ram_retain;
        logic kbd_wake_en;
        logic osc1k_en;
    } smp_gate_s;

    typedef struct packed {
        logic svm_en;
        logic svm_stop_en;
        logic pdc;
        logic ppdc;
        logic dbg_en;
        logic stop_en;
        logic irq_en;
        logic [2:0] rate;
        logic osc_keep;
        logic ref_keep;
        logic [7:0] kbd_en;
    } smp_cfg_s;

    localparam smp_cfg_s SMP_CFG_RST = '{default: '0};

    localparam smp_gate_s SMP_GATE_RUN = '{
        periph_clk_en: 1'b1, debug_clk_en: 1'b1, clkgen_mode: SMP_CG_ACTIVE,
        osc_keep: 1'b1, ref_keep: 1'b1, regulator_standby: 1'b0,
        converter_standby: 1'b0, pin_latch: 1'b0, pin_force_reset: 1'b0,
        ram_retain: 1'b1, kbd_wake_en: 1'b0, osc1k_en: 1'b0
    };

endpackage : smp_pkg

// [rtl/smp_sync.sv]
// Two-stage synchroniser for wake pins and the debug link command
module smp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Pins
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_q;

    // ----------------------------------------
    // Pin events land here first while the rest of the chip is halted
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : smp_sync

// [rtl/smp_ctrl.sv]
// Stop mode power controller: stop state choice, gating, wake handling and registers
module smp_ctrl import smp_pkg::*; #(
    parameter int KBD_W = 8,
    parameter int TICK_CYCLES = SMP_WAKE_TICK_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [7:0] reg_rdata,
    // CPU core
    input wire logic stop_exec,
    output logic cpu_halt,
    output logic cpu_resume,
    output smp_src_e wake_vector,
    output logic sys_reset,
    output logic illegal_op_reset,
    output logic periph_reset,
    // Wake pins
    input wire logic reset_pin_n,
    input wire logic irq_pin_n,
    input wire logic [KBD_W-1:0] kbd_pins,
    // Debug link
    input wire logic bkgd_cmd,
    input wire logic mem_status_req,
    output logic mem_status_grant,
    output logic mem_status_err,
    output logic debug_enter,
    // Power and clock gating
    output smp_gate_s gate,
    output logic periodic_flag
);

    // ----------------------------------------
    // Parameter checks
    // ----------------------------------------
    localparam int TW = $clog2(TICK_CYCLES + 1);

    if (KBD_W < 1 || KBD_W > 8) begin : g_kbd_chk
        $error("KBD_W must lie in 1..8");
    end
    if (TICK_CYCLES < 2) begin : g_tick_chk
        $error("TICK_CYCLES must be at least 2");
    end

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        smp_state_e st;
        smp_cfg_s cfg;
        logic dbg_stop;
        logic reg_active;
        logic per_flag;
        logic ppd_flag;
        logic [TW-1:0] tick_cnt;
        logic [15:0] rate_cnt;
        smp_src_e src;
        smp_gate_s gate;
        logic cpu_halt;
        logic cpu_resume;
        logic sys_reset;
        logic ill_reset;
        logic periph_reset;
        logic mem_grant;
        logic mem_err;
        logic dbg_enter;
        logic [7:0] rdata;
    } smp_ctrl_s;

    smp_ctrl_s s_q, s_d;

    logic reset_n_s;
    logic irq_n_s;
    logic bkgd_s;
    logic [KBD_W-1:0] kbd_s;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    smp_sync #(
        .W(KBD_W + 3),
        .RST_VAL({2'b11, 1'b0, {KBD_W{1'b0}}})
    ) u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .async_in({reset_pin_n, irq_pin_n, bkgd_cmd, kbd_pins}),
        .sync_out({reset_n_s, irq_n_s, bkgd_s, kbd_s})
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [15:0] rate_ticks(input logic [2:0] rate);
        rate_ticks = SMP_RATE_BASE << (rate - 3'h1);
    endfunction : rate_ticks

    function automatic logic [7:0] bit8(input int pos, input logic val);
        bit8 = 8'h00;
        bit8[pos] = val;
    endfunction : bit8

    // Gating seen by the chip in each stop state
    function automatic smp_gate_s stop_gate(input smp_state_e st, input smp_cfg_s c,
                                            input logic dbg, input logic reg_on, input logic pin_hold);
        smp_gate_s g;
        g = SMP_GATE_RUN;
        g.periph_clk_en = 1'b0;
        g.converter_standby = 1'b1;
        g.debug_clk_en = dbg;
        g.regulator_standby = !reg_on;
        g.osc1k_en = (c.rate != SMP_RATE_OFF);
        g.pin_latch = pin_hold;
        unique case (st)
            SMP_LIGHT: begin
                g.clkgen_mode = dbg ? SMP_CG_ACTIVE : SMP_CG_STANDBY;
                g.osc_keep = dbg | c.osc_keep;
                g.ref_keep = dbg | c.ref_keep;
                g.kbd_wake_en = 1'b1;
            end
            SMP_MID: begin
                g.clkgen_mode = SMP_CG_OFF;
                g.osc_keep = 1'b0;
                g.ref_keep = 1'b0;
                g.kbd_wake_en = 1'b0;
                g.pin_latch = 1'b1;
            end
            default: begin
                g.clkgen_mode = SMP_CG_OFF;
                g.osc_keep = 1'b0;
                g.ref_keep = 1'b0;
                g.kbd_wake_en = 1'b0;
                g.pin_force_reset = 1'b1;
                g.ram_retain = 1'b0;
            end
        endcase
        return g;
    endfunction : stop_gate

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    logic tick;
    logic per_hit;
    logic kbd_hit;
    logic wr_ack;
    logic deeper_wake;
    logic mid_wake;
    smp_state_e tgt;

    always_comb begin
        s_d = s_q;
        tick = 1'b0;
        per_hit = 1'b0;
        kbd_hit = |(kbd_s & s_q.cfg.kbd_en[KBD_W-1:0]);
        wr_ack = reg_we && reg_addr == SMP_A_PWR_TWO && reg_wdata[SMP_B_PIN_ACK];
        deeper_wake = 1'b0;
        mid_wake = 1'b0;
        tgt = SMP_LIGHT;

        s_d.cpu_resume = 1'b0;
        s_d.sys_reset = 1'b0;
        s_d.ill_reset = 1'b0;
        s_d.periph_reset = 1'b0;
        s_d.dbg_enter = 1'b0;
        s_d.mem_grant = 1'b0;
        s_d.mem_err = 1'b0;
        s_d.rdata = 8'h00;

        // Self-clocked periodic source; kept off entirely when its rate is zero
        if (s_q.cfg.rate == SMP_RATE_OFF) begin
            s_d.tick_cnt = '0;
            s_d.rate_cnt = 16'h0000;
        end else if (s_q.tick_cnt == TW'(TICK_CYCLES - 1)) begin
            s_d.tick_cnt = '0;
            tick = 1'b1;
        end else begin
            s_d.tick_cnt = s_q.tick_cnt + TW'(1);
        end
        if (tick) begin
            if (s_q.rate_cnt >= rate_ticks(s_q.cfg.rate) - 16'h0001) begin
                s_d.rate_cnt = 16'h0000;
                per_hit = 1'b1;
            end else begin
                s_d.rate_cnt = s_q.rate_cnt + 16'h0001;
            end
        end

        // Register writes
        if (reg_we) begin
            unique case (reg_addr)
                SMP_A_PWR_ONE: begin
                    s_d.cfg.svm_en = reg_wdata[SMP_B_SVM_EN];
                    s_d.cfg.svm_stop_en = reg_wdata[SMP_B_SVM_STOP_EN];
                end
                SMP_A_PWR_TWO: begin
                    s_d.cfg.pdc = reg_wdata[SMP_B_PDC];
                    s_d.cfg.ppdc = reg_wdata[SMP_B_PPDC];
                end
                SMP_A_DEBUG: s_d.cfg.dbg_en = reg_wdata[SMP_B_DBG_EN];
                SMP_A_SYS_OPT: begin
                    s_d.cfg.stop_en = reg_wdata[SMP_B_STOP_EN];
                    s_d.cfg.irq_en = reg_wdata[SMP_B_IRQ_EN];
                end
                SMP_A_PERIODIC: begin
                    s_d.cfg.rate = reg_wdata[SMP_B_RATE_LO +: 3];
                    if (reg_wdata[SMP_B_PER_FLAG]) begin
                        s_d.per_flag = 1'b0;
                    end
                end
                SMP_A_CLKGEN: begin
                    s_d.cfg.osc_keep = reg_wdata[SMP_B_OSC_KEEP];
                    s_d.cfg.ref_keep = reg_wdata[SMP_B_REF_KEEP];
                end
                SMP_A_KBD_EN: s_d.cfg.kbd_en = reg_wdata;
                default: ;
            endcase
        end
        // Release the pin latches and the flag together
        if (wr_ack) begin
            s_d.ppd_flag = 1'b0;
            s_d.gate.pin_latch = 1'b0;
        end
        // Hardware set wins over a same-cycle clear
        if (per_hit) begin
            s_d.per_flag = 1'b1;
        end

        // Register reads, data in the following cycle
        if (reg_re) begin
            unique case (reg_addr)
                SMP_A_PWR_ONE: s_d.rdata = bit8(SMP_B_SVM_EN, s_q.cfg.svm_en)
                                         | bit8(SMP_B_SVM_STOP_EN, s_q.cfg.svm_stop_en);
                SMP_A_PWR_TWO: s_d.rdata = bit8(SMP_B_PDC, s_q.cfg.pdc) | bit8(SMP_B_PPDC, s_q.cfg.ppdc)
                                         | bit8(SMP_B_PPD_FLAG, s_q.ppd_flag);
                SMP_A_DEBUG: s_d.rdata = bit8(SMP_B_DBG_EN, s_q.cfg.dbg_en);
                SMP_A_SYS_OPT: s_d.rdata = bit8(SMP_B_STOP_EN, s_q.cfg.stop_en) | bit8(SMP_B_IRQ_EN, s_q.cfg.irq_en);
                SMP_A_PERIODIC: s_d.rdata = {4'h0, s_q.per_flag, s_q.cfg.rate};
                SMP_A_CLKGEN: s_d.rdata = bit8(SMP_B_OSC_KEEP, s_q.cfg.osc_keep)
                                        | bit8(SMP_B_REF_KEEP, s_q.cfg.ref_keep);
                SMP_A_KBD_EN: s_d.rdata = s_q.cfg.kbd_en;
                default: s_d.rdata = {2'b00, s_q.src[2:0], s_q.st[2:0]};
            endcase
        end

        // Debug memory-with-status commands
        if (mem_status_req) begin
            if (s_q.st == SMP_RUN) begin
                s_d.mem_grant = 1'b1;
            end else begin
                s_d.mem_err = 1'b1;
            end
        end

        unique case (s_q.st)
            SMP_RUN: begin
                if (stop_exec) begin
                    if (!s_q.cfg.stop_en) begin
                        s_d.ill_reset = 1'b1;
                    end else begin
                        // Debug or monitor-in-stop pin the choice to the lightest state
                        if (s_q.cfg.pdc && !s_q.cfg.dbg_en && !s_q.cfg.svm_stop_en) begin
                            tgt = s_q.cfg.ppdc ? SMP_MID : SMP_DEEP;
                        end
                        s_d.st = tgt;
                        s_d.dbg_stop = s_q.cfg.dbg_en;
                        s_d.reg_active = s_q.cfg.dbg_en
                                       | (s_q.cfg.svm_en & s_q.cfg.svm_stop_en);
                        s_d.cpu_halt = 1'b1;
                        s_d.src = SMP_SRC_NONE;
                        s_d.gate = stop_gate(tgt, s_q.cfg, s_q.cfg.dbg_en,
                                             s_q.cfg.dbg_en | (s_q.cfg.svm_en & s_q.cfg.svm_stop_en),
                                             s_q.gate.pin_latch);
                    end
                end
            end
            SMP_LIGHT: begin
                // State is untouched, so register, logic and RAM contents survive
                if (!reset_n_s) begin
                    s_d.src = SMP_SRC_RESET;
                    s_d.sys_reset = 1'b1;
                end else if (s_q.dbg_stop && bkgd_s) begin
                    s_d.src = SMP_SRC_DEBUG;
                    s_d.dbg_enter = 1'b1;
                end else if (!irq_n_s && s_q.cfg.irq_en) begin
                    s_d.src = SMP_SRC_IRQ;
                end else if (kbd_hit) begin
                    s_d.src = SMP_SRC_KBD;
                end else if (per_hit) begin
                    s_d.src = SMP_SRC_PERIODIC;
                end
                if (s_d.src != SMP_SRC_NONE) begin
                    s_d.st = SMP_RUN;
                    s_d.cpu_halt = 1'b0;
                    s_d.cpu_resume = 1'b1;
                    s_d.gate = SMP_GATE_RUN;
                end
            end
            SMP_MID: begin
                if (!reset_n_s) begin
                    s_d.src = SMP_SRC_RESET;
                end else if (!irq_n_s) begin
                    s_d.src = SMP_SRC_IRQ;
                end else if (per_hit) begin
                    s_d.src = SMP_SRC_PERIODIC;
                end
                mid_wake = s_d.src != SMP_SRC_NONE;
                deeper_wake = mid_wake;
            end
            default: begin
                if (!reset_n_s) begin
                    s_d.src = SMP_SRC_RESET;
                end else if (!irq_n_s) begin
                    s_d.src = SMP_SRC_IRQ;
                end
                deeper_wake = s_d.src != SMP_SRC_NONE;
            end
        endcase

        // Deeper wake restarts as from power-on, except for latched pins, ppd_flag and the wake source
        if (deeper_wake) begin
            s_d.cfg = SMP_CFG_RST;
            s_d.per_flag = 1'b0;
            s_d.tick_cnt = '0;
            s_d.rate_cnt = 16'h0000;
            s_d.st = SMP_RUN;
            s_d.cpu_halt = 1'b0;
            s_d.sys_reset = 1'b1;
            s_d.periph_reset = 1'b1;
            s_d.gate = SMP_GATE_RUN;
            s_d.gate.pin_latch = mid_wake | s_q.gate.pin_latch;
            s_d.ppd_flag = mid_wake | s_q.ppd_flag;
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{st: SMP_RUN, cfg: SMP_CFG_RST, src: SMP_SRC_NONE, gate: SMP_GATE_RUN, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // Outputs, all straight from the state register
    // ----------------------------------------
    assign reg_rdata = s_q.rdata;
    assign cpu_halt = s_q.cpu_halt;
    assign cpu_resume = s_q.cpu_resume;
    assign wake_vector = s_q.src;
    assign sys_reset = s_q.sys_reset;
    assign illegal_op_reset = s_q.ill_reset;
    assign periph_reset = s_q.periph_reset;
    assign mem_status_grant = s_q.mem_grant;
    assign mem_status_err = s_q.mem_err;
    assign debug_enter = s_q.dbg_enter;
    assign gate = s_q.gate;
    assign periodic_flag = s_q.per_flag;

endmodule : smp_ctrl

// [testbench/smp_ctrl_monitor.sv]
// Checker of stop entry, gating and wake outputs of the stop mode power controller
module smp_ctrl_monitor import smp_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Core and debug link
    input wire logic stop_exec,
    input wire logic cpu_halt,
    input wire logic cpu_resume,
    input wire smp_src_e wake_vector,
    input wire logic illegal_op_reset,
    input wire logic mem_status_req,
    input wire logic mem_status_grant,
    input wire logic mem_status_err,
    input wire logic debug_enter,
    // Gating
    input wire smp_gate_s gate
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    halt_cause_a: assert property ($rose(cpu_halt) |-> $past(stop_exec)) else $error("halt without stop");
    periph_gate_a: assert property (cpu_halt |-> !gate.periph_clk_en && gate.converter_standby)
        else $error("peripheral clock or converter live in stop");
    dbg_regulator_a: assert property (cpu_halt && gate.debug_clk_en |-> !gate.regulator_standby
        && gate.clkgen_mode == SMP_CG_ACTIVE) else $error("debug stop lost regulation");
    dbg_light_a: assert property (cpu_halt && gate.debug_clk_en |-> !gate.pin_latch && !gate.pin_force_reset)
        else $error("debug stop went deeper");
    deep_clock_a: assert property (cpu_halt && gate.clkgen_mode == SMP_CG_OFF |-> !gate.osc_keep
        && !gate.ref_keep && !gate.kbd_wake_en) else $error("source kept in deeper stop");
    deep_ram_a: assert property (cpu_halt && gate.pin_force_reset |-> !gate.ram_retain && !gate.pin_latch)
        else $error("deepest stop gating wrong");
    mem_err_a: assert property (mem_status_req && cpu_halt |=> mem_status_err && !mem_status_grant)
        else $error("memory access while stopped");
    mem_grant_a: assert property (mem_status_req && !cpu_halt && !stop_exec |=> mem_status_grant)
        else $error("no grant while running");
    stray_resume_a: assert property (cpu_resume |-> !cpu_halt && $past(cpu_halt))
        else $error("stray resume");
    dbg_wake_a: assert property (debug_enter |-> wake_vector == SMP_SRC_DEBUG)
        else $error("debug entry source");
    illegal_stop_a: assert property (illegal_op_reset |-> !cpu_halt && $past(stop_exec))
        else $error("stray illegal");
endmodule : smp_ctrl_monitor

bind smp_ctrl smp_ctrl_monitor u_mon (.sys_clk(sys_clk), .rst_n(rst_n), .stop_exec(stop_exec),
    .cpu_halt(cpu_halt), .cpu_resume(cpu_resume), .wake_vector(wake_vector), .illegal_op_reset(illegal_op_reset),
    .mem_status_req(mem_status_req), .mem_status_grant(mem_status_grant), .mem_status_err(mem_status_err),
    .debug_enter(debug_enter), .gate(gate));

// [testbench/smp_wake_model.sv]
// Wake pin and debug link model facing the controller
module smp_wake_model import smp_pkg::*; (
    // Command from the bench
    input wire logic go,
    input wire smp_src_e kind,
    // Wake pins and debug link
    output logic reset_pin_n,
    output logic irq_pin_n,
    output logic [7:0] kbd_pins,
    output logic bkgd_cmd
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released pins sit at their pull level: wake pins high, keyboard low
    assign reset_pin_n = !(go && kind == SMP_SRC_RESET);
    assign irq_pin_n = !(go && kind == SMP_SRC_IRQ);
    assign kbd_pins = (go && kind == SMP_SRC_KBD) ? 8'h81 : 8'h00;
    assign bkgd_cmd = go && kind == SMP_SRC_DEBUG;
endmodule : smp_wake_model

// [testbench/tb.sv]
// Self-checking bench of the stop mode power controller
module tb import smp_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'h0, rst_n = 1'h0, reg_we = 1'h0, reg_re = 1'h0, stop_exec = 1'h0;
    logic mem_status_req = 1'h0, go = 1'h0, re_q = 1'h0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, kbd_pins;
    logic cpu_halt, cpu_resume, sys_reset, illegal_op_reset, periph_reset, reset_pin_n, irq_pin_n, bkgd_cmd;
    logic mem_status_grant, mem_status_err, debug_enter, periodic_flag;
    smp_src_e kind = SMP_SRC_NONE, wake_vector;
    smp_gate_s gate;
    int fails = 0, total_checks = 0, cycles = 0;
    logic [31:0] seed = 32'hDF3F2E18;
    logic [7:0] rq[$];
    logic [7:0] mask[7] = '{8'h03, 8'h03, 8'h01, 8'h03, 8'h07, 8'h03, 8'hFF};
    smp_src_e srcs[4] = '{SMP_SRC_IRQ, SMP_SRC_KBD, SMP_SRC_PERIODIC, SMP_SRC_RESET};

    smp_wake_model u_wake (.go(go), .kind(kind), .reset_pin_n(reset_pin_n), .irq_pin_n(irq_pin_n),
        .kbd_pins(kbd_pins), .bkgd_cmd(bkgd_cmd));
    // Short tick keeps periodic wake within a few dozen cycles
    smp_ctrl #(.TICK_CYCLES(4)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .stop_exec(stop_exec),
        .cpu_halt(cpu_halt), .cpu_resume(cpu_resume), .wake_vector(wake_vector), .sys_reset(sys_reset),
        .illegal_op_reset(illegal_op_reset), .periph_reset(periph_reset), .reset_pin_n(reset_pin_n),
        .irq_pin_n(irq_pin_n), .kbd_pins(kbd_pins), .bkgd_cmd(bkgd_cmd), .mem_status_req(mem_status_req),
        .mem_status_grant(mem_status_grant), .mem_status_err(mem_status_err), .debug_enter(debug_enter),
        .gate(gate), .periodic_flag(periodic_flag));

    always #5 sys_clk = !sys_clk;

    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task automatic check(string n, logic [15:0] s, logic [15:0] e);
        total_checks++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : check

    task automatic stop_test();
        if (fails == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test

    always @(posedge sys_clk) begin
        cycles++;
        if (re_q) check("rdata", reg_rdata, rq.pop_front());
        re_q <= reg_re;
        if (cycles == 20000) begin
            fails++;
            stop_test();
        end
    end

    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic wr(logic [2:0] a, logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'h1;
        @(posedge sys_clk);
        reg_we <= 1'h0;
        @(posedge sys_clk);
    endtask : wr

    task automatic rd(logic [2:0] a, logic [7:0] e);
        reg_addr <= a;
        reg_re <= 1'h1;
        rq.push_back(e);
        @(posedge sys_clk);
        reg_re <= 1'h0;
        @(posedge sys_clk);
    endtask : rd

    function automatic smp_gate_s stop_gate(logic [1:0] st, logic dbg, logic mon, logic o1);
        smp_gate_s g = SMP_GATE_RUN;
        g.periph_clk_en = 1'h0;
        g.debug_clk_en = dbg;
        g.regulator_standby = !(dbg || mon);
        g.converter_standby = 1'h1;
        g.osc1k_en = o1;
        if (st == 2'h1) begin
            g.clkgen_mode = dbg ? SMP_CG_ACTIVE : SMP_CG_STANDBY;
            g.ref_keep = dbg;
            g.kbd_wake_en = 1'h1;
        end else begin
            g.clkgen_mode = SMP_CG_OFF;
            g.osc_keep = 1'h0;
            g.ref_keep = 1'h0;
            g.pin_latch = st == 2'h2;
            g.pin_force_reset = st == 2'h3;
            g.ram_retain = st == 2'h2;
        end
        return g;
    endfunction : stop_gate

    task automatic stop_chk(logic [1:0] st, logic dbg, logic mon, logic o1);
        stop_exec <= 1'h1;
        @(posedge sys_clk);
        stop_exec <= 1'h0;
        #1;
        check("halt", cpu_halt, 1'h1);
        check("gate", gate, stop_gate(st, dbg, mon, o1));
    endtask : stop_chk

    task automatic wake(smp_src_e k, logic d, int n);
        kind <= k;
        go <= k != SMP_SRC_PERIODIC;
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            #1;
            if (cpu_halt === 1'h0) break;
        end
        check("resume", cpu_resume, !d);
        check("vector", wake_vector, k);
        check("sys_reset", sys_reset, d || k == SMP_SRC_RESET);
        check("periph_reset", periph_reset, d);
        check("debug_enter", debug_enter, k == SMP_SRC_DEBUG);
        go <= 1'h0;
        repeat (4) @(posedge sys_clk);
    endtask : wake

    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'h1;
        check("gate_rst", gate, SMP_GATE_RUN);
        rd(SMP_A_STATUS, 8'h00);
        mem_status_req <= 1'h1;
        @(posedge sys_clk);
        mem_status_req <= 1'h0;
        #1;
        check("grant", mem_status_grant, 1'h1);
        for (int a = 0; a < 7; a++) begin
            seed = lfsr(seed);
            wr(3'(a), seed[7:0]);
            rd(3'(a), seed[7:0] & mask[a]);
            wr(3'(a), 8'h00);
        end
        wr(SMP_A_STATUS, 8'hFF);
        rd(SMP_A_STATUS, 8'h00);
        stop_exec <= 1'h1;
        @(posedge sys_clk);
        stop_exec <= 1'h0;
        #1;
        check("illegal", {illegal_op_reset, cpu_halt}, 2'h2);
        wr(SMP_A_SYS_OPT, 8'h03);
        wr(SMP_A_CLKGEN, 8'h01);
        wr(SMP_A_KBD_EN, 8'hFF);
        for (int i = 0; i < 4; i++) begin
            wr(SMP_A_PERIODIC, (i == 2) ? 8'h01 : 8'h00);
            stop_chk(2'h1, 1'h0, 1'h0, i == 2);
            wake(srcs[i], 1'h0, 60);
            if (i == 2) check("pflag", periodic_flag, 1'h1);
        end
        wr(SMP_A_SYS_OPT, 8'h03);
        wr(SMP_A_DEBUG, 8'h01);
        wr(SMP_A_PWR_TWO, 8'h03);
        stop_chk(2'h1, 1'h1, 1'h0, 1'h0);
        mem_status_req <= 1'h1;
        @(posedge sys_clk);
        mem_status_req <= 1'h0;
        #1;
        check("mem_err", mem_status_err, 1'h1);
        wake(SMP_SRC_DEBUG, 1'h0, 12);
        wr(SMP_A_DEBUG, 8'h00);
        stop_chk(2'h2, 1'h0, 1'h0, 1'h0);
        wake(SMP_SRC_IRQ, 1'h1, 12);
        check("latch", gate.pin_latch, 1'h1);
        rd(SMP_A_PWR_TWO, 8'h08);
        wr(SMP_A_PWR_TWO, 8'h04);
        rd(SMP_A_PWR_TWO, 8'h00);
        check("latch_ack", gate.pin_latch, 1'h0);
        wr(SMP_A_SYS_OPT, 8'h01);
        wr(SMP_A_PWR_TWO, 8'h02);
        wr(SMP_A_KBD_EN, 8'hFF);
        stop_chk(2'h3, 1'h0, 1'h0, 1'h0);
        kind <= SMP_SRC_KBD;
        go <= 1'h1;
        repeat (6) @(posedge sys_clk);
        check("kbd_deep", cpu_halt, 1'h1);
        wake(SMP_SRC_RESET, 1'h1, 12);
        wr(SMP_A_SYS_OPT, 8'h01);
        wr(SMP_A_CLKGEN, 8'h01);
        wr(SMP_A_PWR_ONE, 8'h03);
        wr(SMP_A_PWR_TWO, 8'h02);
        stop_chk(2'h1, 1'h0, 1'h1, 1'h0);
        wake(SMP_SRC_RESET, 1'h0, 12);
        stop_test();
    end
endmodule : tb
